// [asc_map.vh]
// timing and field constants for the static memory host controller
// Operation
// - write needs chip select, write strobe and a lane select low
// - write data valid 5.0 ns before the strobe edge ending the write
// - write strobe low with output enable low: float delay plus setup
// - wait 100.0 us after stable supply before first access
// - address valid at write start, and 7.0 ns before write end
// - lane selects low at least 7.0 ns before write end
// - deselect before retention; 10.0 ns recovery after supply returns
// - host never drives data while the memory drives it
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// ----------------------------------------
// clock and printed times (picoseconds)
// ----------------------------------------
`define ASC_CLK_PS 25000
`define ASC_STABLE_WAIT_PS 100000000
`define ASC_ADDR_SETUP_TO_END_PS 7000
`define ASC_LANE_SELECT_TO_END_PS 7000
`define ASC_DATA_SETUP_TO_END_PS 5000
`define ASC_STROBE_TO_FLOAT_PS 5000
`define ASC_RETENTION_RECOVERY_PS 10000
`define ASC_READ_CYCLE_PS 10000
`define ASC_ADDR_TO_DATA_PS 10000
`define ASC_LANE_RELEASE_PS 6000
// ----------------------------------------
// derived counts, least times rounded up
// ----------------------------------------
`define ASC_CEIL(t) (((t) + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_STABLE_WAIT_CYC `ASC_CEIL(`ASC_STABLE_WAIT_PS)
`define ASC_WRITE_LOW_PS (`ASC_STROBE_TO_FLOAT_PS + `ASC_DATA_SETUP_TO_END_PS)
`define ASC_WRITE_LOW_CYC `ASC_CEIL(`ASC_WRITE_LOW_PS)
`define ASC_RECOVERY_CYC `ASC_CEIL(`ASC_RETENTION_RECOVERY_PS)
`define ASC_READ_CYC `ASC_CEIL(`ASC_ADDR_TO_DATA_PS)
`define ASC_TURN_CYC `ASC_CEIL(`ASC_LANE_RELEASE_PS)
`define ASC_CNT_W 16
`endif

// [asc_delay.v]
// down counter that flags when a programmed wait has elapsed
`timescale 1ns/1ps
module asc_delay #(
  parameter W = 16
) (
  input wire clk,            // system clock
  input wire reset_n,        // sync reset, active low
  input wire load,           // start a wait
  input wire [W-1:0] count,  // cycles to wait
  output reg done            // high once the wait has run out
);
  reg [W-1:0] left;
  // ----------------------------------------
  // count down, flag at zero
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      left <= {W{1'b0}};
      done <= 1'b0;
    end
    else if (load)
    begin
      left <= count;
      done <= 1'b0;
    end
    else if (left > {{(W-1){1'b0}}, 1'b1})
      left <= left - {{(W-1){1'b0}}, 1'b1};
    else
    begin
      left <= {W{1'b0}};
      done <= 1'b1;
    end
  end
endmodule

// [asc_host.v]
// host controller driving an asynchronous 16-bit static memory
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_host #(
  parameter AW = 20,                                  // address width
  parameter STABLE_WAIT_CYC = `ASC_STABLE_WAIT_CYC    // power-up wait
) (
  input wire clk,                  // 40 MHz clock
  input wire reset_n,              // sync reset, active low
  input wire req_valid,            // user request strobe
  input wire req_write,            // 1 write, 0 read
  input wire [AW-1:0] req_addr,    // word address
  input wire [15:0] req_wdata,     // write data
  input wire [1:0] req_lanes,      // bit0 low byte, bit1 high byte
  input wire retain_req,           // level: supply about to drop
  output reg req_ready,            // idle and able to take a request
  output reg rsp_valid,            // one-cycle pulse, read data valid
  output reg [15:0] rsp_rdata,     // read data, unused lanes zero
  output reg retained,             // chip deselected for retention
  output reg chip_select_n,        // memory chip select
  output reg output_enable_n,      // memory output enable
  output reg write_strobe_n,       // memory write strobe
  output reg low_byte_select_n,    // low lane select
  output reg high_byte_select_n,   // high lane select
  output reg [AW-1:0] mem_addr,    // memory address
  output reg [15:0] data_out,      // data driven to memory
  output reg data_oe,              // high while host drives data
  input wire [15:0] data_in        // data bus as seen on the pins
);
  localparam CW = `ASC_CNT_W;
  // counts kept as integers and cut to the counter width where loaded
  localparam integer WRITE_LOW_CYC = `ASC_WRITE_LOW_CYC;
  localparam integer READ_WAIT_CYC = `ASC_READ_CYC + 2;
  localparam integer TURN_CYC = `ASC_TURN_CYC;
  localparam integer RECOVERY_CYC = `ASC_RECOVERY_CYC;
  localparam S_POWER = 3'd0;
  localparam S_IDLE = 3'd1;
  localparam S_WRITE = 3'd2;
  localparam S_READ = 3'd3;
  localparam S_TURN = 3'd4;
  localparam S_RETAIN = 3'd5;
  localparam S_RECOVER = 3'd6;

  reg [2:0] state;
  reg load;
  reg [CW-1:0] load_count;
  wire done;
  reg [15:0] din_meta;
  reg [15:0] din_sync;
  reg ret_meta;
  reg ret_sync;
  reg [1:0] lanes;

  // keep the lane mask on data so unselected bytes read as zero
  function [15:0] lane_mask;
    input [1:0] l;
    begin
      lane_mask = {{8{l[1]}}, {8{l[0]}}};
    end
  endfunction

  asc_delay #(.W(CW)) u_delay (
    .clk(clk),
    .reset_n(reset_n),
    .load(load),
    .count(load_count),
    .done(done)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // read data is async to clk; two stages before the capture register
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      din_meta <= 16'h0000;
      din_sync <= 16'h0000;
      ret_meta <= 1'b0;
      ret_sync <= 1'b0;
    end
    else
    begin
      din_meta <= data_in;
      din_sync <= din_meta;
      ret_meta <= retain_req;
      ret_sync <= ret_meta;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // every wait below is a rounded-up cycle count
  // whole cycle timing
  always @(posedge clk)
  begin
    load <= 1'b0;
    load_count <= {CW{1'b0}};
    rsp_valid <= 1'b0;
    if (!reset_n)
    begin
      state <= S_POWER;
      req_ready <= 1'b0;
      rsp_rdata <= 16'h0000;
      retained <= 1'b0;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      mem_addr <= {AW{1'b0}};
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      lanes <= 2'b00;
      load <= 1'b1;
      load_count <= STABLE_WAIT_CYC[CW-1:0];
    end
    else
    begin
      case (state)
        S_POWER:
        begin
          if (done && !load)
          begin
            state <= S_IDLE;
            req_ready <= 1'b1;
          end
        end
        S_IDLE:
        begin
          if (ret_sync)
          begin
            state <= S_RETAIN;
            req_ready <= 1'b0;
            retained <= 1'b1;
            chip_select_n <= 1'b1;
          end
          else if (req_valid && req_lanes != 2'b00)
          begin
            req_ready <= 1'b0;
            lanes <= req_lanes;
            mem_addr <= req_addr;
            chip_select_n <= 1'b0;
            low_byte_select_n <= ~req_lanes[0];
            high_byte_select_n <= ~req_lanes[1];
            load <= 1'b1;
            if (req_write)
            begin
              state <= S_WRITE;
              write_strobe_n <= 1'b0;
              output_enable_n <= 1'b1;
              // memory outputs already off, oe high
              data_out <= req_wdata;
              data_oe <= 1'b1;
              load_count <= WRITE_LOW_CYC[CW-1:0];
            end
            else
            begin
              state <= S_READ;
              output_enable_n <= 1'b0;
              // two extra cycles cover the data synchroniser
              load_count <= READ_WAIT_CYC[CW-1:0];
            end
          end
        end
        S_WRITE:
        begin
          // data held to the ending edge
          if (done && !load)
          begin
            // strobe rise ends the write; rest stay
            write_strobe_n <= 1'b1;
            state <= S_TURN;
            load <= 1'b1;
            load_count <= TURN_CYC[CW-1:0];
          end
        end
        S_READ:
        begin
          if (done && !load)
          begin
            rsp_rdata <= din_sync & lane_mask(lanes);
            rsp_valid <= 1'b1;
            output_enable_n <= 1'b1;
            chip_select_n <= 1'b1;
            low_byte_select_n <= 1'b1;
            high_byte_select_n <= 1'b1;
            state <= S_TURN;
            load <= 1'b1;
            load_count <= TURN_CYC[CW-1:0];
          end
        end
        S_TURN:
        begin
          // release data a cycle after the strobe rose: zero hold met
          data_oe <= 1'b0;
          chip_select_n <= 1'b1;
          low_byte_select_n <= 1'b1;
          high_byte_select_n <= 1'b1;
          if (done && !load)
          begin
            state <= S_IDLE;
            req_ready <= 1'b1;
          end
        end
        S_RETAIN:
        begin
          if (!ret_sync)
          begin
            state <= S_RECOVER;
            load <= 1'b1;
            load_count <= RECOVERY_CYC[CW-1:0];
          end
        end
        S_RECOVER:
        begin
          if (done && !load)
          begin
            retained <= 1'b0;
            state <= S_IDLE;
            req_ready <= 1'b1;
          end
        end
        default:
        begin
          state <= S_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [asc_host_props.sv]
// assertions on the memory-side pins and the ready, read and retention outputs of the host controller
`timescale 1ns/1ps
module asc_host_props #(
  parameter AW = 20,
  parameter STABLE_WAIT_CYC = 10
) (
  input wire clk, // clock
  input wire reset_n, // sync reset
  input wire retain_req, // supply dropping, raw pin
  input wire req_ready, // idle
  input wire rsp_valid, // read answer
  input wire retained, // retention
  input wire chip_select_n, // chip select
  input wire output_enable_n, // output enable
  input wire write_strobe_n, // write strobe
  input wire low_byte_select_n, // low lane
  input wire high_byte_select_n, // high lane
  input wire [AW-1:0] mem_addr, // address
  input wire [15:0] data_out, // host data
  input wire data_oe // host drives
);
  reg [15:0] up;
  // cycles since reset release, saturating so it never wraps
  always @(posedge clk)
    if (!reset_n) up <= 16'h0;
    else if (up != 16'hffff) up <= up + 16'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr_start; $fell(write_strobe_n); endsequence
  sequence s_wr_hold; !write_strobe_n [*2]; endsequence
  a_write_all_low: assert property (s_wr_start |-> !chip_select_n &&
    !(low_byte_select_n && high_byte_select_n)) else $error("write start");
  a_strobe_width: assert property (s_wr_start |-> s_wr_hold)
    else $error("strobe too short");
  a_write_steady: assert property (!write_strobe_n &&
    $past(!write_strobe_n) |-> $stable(mem_addr) && $stable(data_out) &&
    data_oe && $stable({low_byte_select_n, high_byte_select_n}))
    else $error("unsteady");
  a_end_hold: assert property ($rose(write_strobe_n) |-> data_oe &&
    !chip_select_n) else $error("data gone at write end");
  a_no_clash: assert property (data_oe |-> output_enable_n)
    else $error("bus clash");
  a_read_mode: assert property (!output_enable_n |-> !chip_select_n &&
    write_strobe_n) else $error("bad read mode");
  a_read_answer: assert property ($fell(output_enable_n) |-> ##[2:8] rsp_valid)
    else $error("no read answer");
  a_retain_desel: assert property (retained |-> chip_select_n)
    else $error("selected in retention");
  // leaving retention needs the synchroniser plus at least one recovery cycle
  a_recover_gap: assert property ($fell(retained) |->
    !retain_req && !$past(retain_req, 4)) else $error("no recovery gap");
  a_power_wait: assert property (req_ready |-> up >= STABLE_WAIT_CYC)
    else $error("ready too early");
endmodule
bind asc_host asc_host_props #(.AW(AW), .STABLE_WAIT_CYC(STABLE_WAIT_CYC))
  i_asc_host_props (.clk(clk), .reset_n(reset_n), .req_ready(req_ready),
  .retain_req(retain_req),
  .rsp_valid(rsp_valid), .retained(retained), .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
  .low_byte_select_n(low_byte_select_n), .mem_addr(mem_addr),
  .high_byte_select_n(high_byte_select_n), .data_out(data_out),
  .data_oe(data_oe));

// [asc_mem_model.sv]
// behavioural model of the asynchronous 16-bit static memory
`timescale 1ns/1ps
module asc_mem_model (
  input wire chip_select_n, // chip select
  input wire output_enable_n, // output enable
  input wire write_strobe_n, // write strobe
  input wire low_byte_select_n, // low lane
  input wire high_byte_select_n, // high lane
  input wire [7:0] addr, // word address, low bits
  input wire [15:0] data_out, // host value
  input wire data_oe, // host drives
  output wire [15:0] bus // resolved bus level
);
  reg [15:0] mem [0:255];
  reg [15:0] last;
  integer k;
  wire [1:0] lane_n = {high_byte_select_n, low_byte_select_n};
  // drive only in read mode on selected lanes
  wire rd = !chip_select_n && !output_enable_n && write_strobe_n;
  wire [1:0] drv = {2{rd}} & ~lane_n;
  // output follows the address, never ahead of it
  wire [15:0] q = mem[addr];
  // release at once; no pull, so a free lane flips
  assign bus = data_oe ? data_out : {drv[1] ? q[15:8] : ~last[15:8],
    drv[0] ? q[7:0] : ~last[7:0]};
  initial
  begin
    last = 16'h0;
    for (k = 0; k < 256; k = k + 1) mem[k] = 16'h0;
  end
  // last driven value, kept so a floating lane never repeats it
  always @(q or drv)
  begin
    if (drv[0]) last[7:0] = q[7:0];
    if (drv[1]) last[15:8] = q[15:8];
  end
  // store selected lanes when write strobe or chip select rises while the other is still low
  always @(posedge write_strobe_n or posedge chip_select_n)
    if (chip_select_n ^ write_strobe_n)
    begin
      if (!lane_n[0]) mem[addr][7:0] = bus[7:0];
      if (!lane_n[1]) mem[addr][15:8] = bus[15:8];
    end
endmodule

// [asc_host_tb.sv]
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module asc_host_tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg req_valid = 1'b0;
  reg req_write = 1'b0;
  reg [19:0] req_addr = 20'h0;
  reg [15:0] req_wdata = 16'h0;
  reg [1:0] req_lanes = 2'h0;
  reg retain_req = 1'b0;
  reg [31:0] r;
  reg [1:0] l;
  wire req_ready, rsp_valid, retained, chip_select_n, output_enable_n;
  wire write_strobe_n, low_byte_select_n, high_byte_select_n, data_oe;
  wire [19:0] mem_addr;
  wire [15:0] rsp_rdata, data_out, data_in;
  integer n_mismatch = 0, tests_run = 0, seed = 92430, i, waited;
  reg [15:0] ref_mem [0:255];
  asc_host #(.STABLE_WAIT_CYC(10)) i_asc_host (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .retain_req(retain_req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .retained(retained), .chip_select_n(chip_select_n), .data_oe(data_oe),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .low_byte_select_n(low_byte_select_n), .mem_addr(mem_addr),
    .high_byte_select_n(high_byte_select_n), .data_out(data_out),
    .data_in(data_in));
  asc_mem_model i_asc_mem_model (.chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .low_byte_select_n(low_byte_select_n), .addr(mem_addr[7:0]),
    .high_byte_select_n(high_byte_select_n), .data_out(data_out),
    .data_oe(data_oe), .bus(data_in));
  always #12.5 clk = ~clk;
  // lanes set in ln take the new byte, the others keep the old one
  function [15:0] merge(input [15:0] old, input [15:0] nw, input [1:0] ln);
    merge = {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
  endfunction
  task check(input [15:0] got, input [15:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // bounded wait on a flag; running out ends the run as a failure
  task wait_for(input integer which);
  begin
    waited = 0;
    while ((which == 0 ? req_ready : which == 1 ? rsp_valid : retained)
      !== 1'b1 && waited < 200)
    begin
      @(posedge clk);
      #2;
      waited = waited + 1;
    end
    if (waited == 200)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  endtask
  // one request; held a single cycle since ready is already high
  task access(input w, input [7:0] a, input [15:0] d, input [1:0] ln);
  begin
    // an edge between calls, so req_valid never drops and rises at once
    @(posedge clk);
    #2;
    wait_for(0);
    req_valid = 1'b1;
    req_write = w;
    req_addr = {12'h0, a};
    req_wdata = d;
    req_lanes = ln;
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    if (w) ref_mem[a] = merge(ref_mem[a], d, ln);
    else
    begin
      wait_for(1);
      check(rsp_rdata, merge(16'h0, ref_mem[a], ln));
    end
  end
  endtask
  initial
  begin
    for (i = 0; i < 256; i = i + 1) ref_mem[i] = 16'h0;
    repeat (6) @(posedge clk);
    #2 reset_n = 1'b1;
    wait_for(0);
    check({15'h0, waited >= 10}, 16'h1);
    // every lane code on one word, lanes 00 must change nothing
    access(1'b1, 8'h05, 16'ha55a, 2'h3);
    access(1'b1, 8'h05, 16'h1234, 2'h1);
    access(1'b1, 8'h05, 16'hbeef, 2'h2);
    access(1'b1, 8'h05, 16'hffff, 2'h0);
    for (i = 1; i < 4; i = i + 1)
      access(1'b0, 8'h05, 16'h0, i[1:0]);
    // random back-to-back traffic over a few words
    for (i = 0; i < 60; i = i + 1)
    begin
      r = $random(seed);
      l = (r[6:5] == 2'h0) ? 2'h3 : r[6:5];
      access(r[0], {4'h0, r[4:1]}, r[31:16], l);
    end
    // retention entry and recovery keep the stored data
    retain_req = 1'b1;
    wait_for(2);
    check({15'h0, chip_select_n}, 16'h1);
    repeat (4) @(posedge clk);
    #2 retain_req = 1'b0;
    access(1'b0, 8'h05, 16'h0, 2'h3);
    report_and_stop;
  end
endmodule
